//--- tmsd_test_mode_select_decode.v
// Test mode select decoder: latches the functional mode pins at reset,
// decodes boundary scan or emulation, and detects NMI rising edges.
// Assumes pins are asynchronous to clk and mode select pins are pulled up when undriven.
`timescale 1ns/1ns
`include "tmsd_regs.vh"
module tmsd_test_mode_select_decode (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Mode select pins
   input wire modeSelectHigh,
   input wire modeSelectLow,
   // Test reset pin, sensed only for status
   input wire testResetPin,
   // Nonmaskable interrupt pin
   input wire nmiPin,
   // Decoded configuration
   output reg boundaryScanMode,
   output reg emulationMode,
   output reg reservedMode,
   output reg runEnable,
   output reg scanTrstConflict,
   // Interrupt event
   output reg nmiPulse
);

   // Capture states, one-hot
   localparam ST_CAPTURE = 2'b01;
   localparam ST_RUN = 2'b10;

   reg [2:0] selHighSync;
   reg [2:0] selLowSync;
   reg [2:0] nmiSync;
   reg [2:0] trstSync;
   reg [1:0] functionalModeSelect;
   reg [1:0] next_functionalModeSelect;
   reg [1:0] captureState;
   reg [1:0] next_captureState;
   reg [1:0] captureCount;
   reg [1:0] next_captureCount;
   reg nmiLevel;
   reg trstLevel;
   wire captureOpen;
   wire [1:0] pinMode;
   wire nmiFiltered;
   wire trstFiltered;

   // A change counts once stages two and three agree
   function filt;
      input [2:0] s;
      input prev;
      begin
         filt = (s[1] == s[2]) ? s[2] : prev;
      end
   endfunction

   function isScan;
      input [1:0] code;
      begin
         isScan = (code == `TMSD_MODE_BSCAN);
      end
   endfunction

   function isEmu;
      input [1:0] code;
      begin
         isEmu = (code == `TMSD_MODE_EMU);
      end
   endfunction

   function isReserved;
      input [1:0] code;
      begin
         isReserved = (code == `TMSD_MODE_RSV1) ||
            (code == `TMSD_MODE_RSV2);
      end
   endfunction

   // Synchronisers rest at the pin's pull level, so no false edge
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         selHighSync <= `TMSD_SYNC_ONES;
      end else begin
         selHighSync <= {selHighSync[1:0], modeSelectHigh};
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         selLowSync <= `TMSD_SYNC_ONES;
      end else begin
         selLowSync <= {selLowSync[1:0], modeSelectLow};
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         nmiSync <= `TMSD_SYNC_ZERO;
      end else begin
         nmiSync <= {nmiSync[1:0], nmiPin};
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         trstSync <= `TMSD_SYNC_ZERO;
      end else begin
         trstSync <= {trstSync[1:0], testResetPin};
      end
   end

   assign pinMode = {filt(selHighSync, functionalModeSelect[1]),
                     filt(selLowSync, functionalModeSelect[0])};
   assign nmiFiltered = filt(nmiSync, nmiLevel);
   assign trstFiltered = filt(trstSync, trstLevel);

   // Capture window: first cycles after release while the sync fills
   always @* begin
      next_captureState = captureState;
      next_captureCount = captureCount;
      next_functionalModeSelect = functionalModeSelect;
      case (captureState)
         ST_CAPTURE: begin
            next_functionalModeSelect = pinMode;
            next_captureCount = captureCount + `TMSD_COUNT_STEP;
            if (captureCount == `TMSD_CAPTURE_LAST)
               next_captureState = ST_RUN;
         end
         ST_RUN: begin
            next_captureState = ST_RUN;
         end
         default: begin
            next_captureState = ST_CAPTURE;
         end
      endcase
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         captureState <= ST_CAPTURE;
         captureCount <= `TMSD_COUNT_ZERO;
         functionalModeSelect <= `TMSD_MODE_EMU;
      end else begin
         captureState <= next_captureState;
         captureCount <= next_captureCount;
         functionalModeSelect <= next_functionalModeSelect;
      end
   end

   assign captureOpen = (captureState == ST_CAPTURE);

   // Decoded configuration, held from capture until the next reset
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         boundaryScanMode <= 1'b0;
      end else begin
         boundaryScanMode <= isScan(functionalModeSelect);
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         emulationMode <= 1'b1;
      end else begin
         emulationMode <= isEmu(functionalModeSelect);
      end
   end

   // Reserved codes are only reported; the core still runs
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reservedMode <= 1'b0;
      end else begin
         reservedMode <= isReserved(functionalModeSelect);
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         runEnable <= 1'b0;
      end else begin
         runEnable <= !captureOpen;
      end
   end

   // Filtered test reset level, kept apart from the conflict flag
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         trstLevel <= 1'b0;
      end else begin
         trstLevel <= trstFiltered;
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         scanTrstConflict <= 1'b0;
      end else begin
         scanTrstConflict <=
            isScan(functionalModeSelect) && trstFiltered;
      end
   end

   // Edge detector: a held high level gives a single pulse
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         nmiLevel <= 1'b0;
      end else begin
         nmiLevel <= nmiFiltered;
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         nmiPulse <= 1'b0;
      end else begin
         nmiPulse <= nmiFiltered && !nmiLevel;
      end
   end
endmodule

//--- tmsd_regs.vh
// Constants for the test mode select decoder.
// Assumes inclusion by the single design file only.
`ifndef TMSD_REGS_VH
`define TMSD_REGS_VH
`define TMSD_MODE_BSCAN 2'h0
`define TMSD_MODE_RSV1 2'h1
`define TMSD_MODE_RSV2 2'h2
`define TMSD_MODE_EMU 2'h3
`define TMSD_SYNC_ZERO 3'h0
`define TMSD_SYNC_ONES 3'h7
`define TMSD_COUNT_ZERO 2'h0
`define TMSD_COUNT_STEP 2'h1
`define TMSD_CAPTURE_LAST 2'h3
`endif

//--- tmsd_assertions.sv
// Checker: decoded mode flags and NMI pulse timing.
// Assumes it is bound to the decoder top.
`timescale 1ns/1ns
module tmsd_assertions(input wire clk, resetn, modeSelectHigh,
   modeSelectLow, nmiPin, boundaryScanMode, emulationMode,
   reservedMode, runEnable, nmiPulse);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
wire [1:0] c = {modeSelectHigh, modeSelectLow};
chk_scan_code: assert property ($rose(runEnable) |->
   boundaryScanMode == (c == 2'h0)) else $error("scan flag");
chk_rsv_code: assert property ($rose(runEnable) |->
   reservedMode == (c == 2'h1 || c == 2'h2)) else $error("rsv flag");
chk_emu_code: assert property ($rose(runEnable) |->
   emulationMode == (c == 2'h3)) else $error("emu flag");
chk_run_up: assert property ($rose(resetn) |->
   ##[3:6] runEnable) else $error("run late");
chk_mode_hold: assert property ($past(runEnable) |->
   $stable({boundaryScanMode, emulationMode, reservedMode})) else $error("hold");
chk_nmi_edge: assert property ($rose(nmiPin) |->
   ##[2:6] nmiPulse) else $error("nmi lost");
chk_nmi_once: assert property (nmiPulse |=>
   !nmiPulse) else $error("nmi long");
endmodule
bind tmsd_test_mode_select_decode tmsd_assertions chk(.*);

//--- tmsd_board.sv
// Board model: mode straps with pull-ups, test reset pulled down.
// Assumes the bench chooses whether the straps are fitted.
`timescale 1ns/1ns
module tmsd_board(input wire strapOn, input wire [1:0] code,
   output wire modeSelectHigh, modeSelectLow, testResetPin);
assign {modeSelectHigh, modeSelectLow} = strapOn ? code : 2'h3;
assign testResetPin = 1'b0;
endmodule

//--- test_mode_select_decode_bench.sv
// Bench: strap sweep and NMI edge count against a small model.
// Assumes the board model and checker are compiled first.
`timescale 1ns/1ns
module test_mode_select_decode_bench;
reg clk = 0, resetn = 0, nmiPin = 0, strapOn = 0;
reg [1:0] code = 2'h0;
reg [31:0] rs = 32'h2D4F96AC;
integer n_errors = 0, checks_done = 0, i, p = 0;
wire hi, lo, trst, bs, emu, rsv, run, np, conf;
function [31:0] xorshift(input [31:0] v);
   xorshift = v ^ (v << 13);
   xorshift = xorshift ^ (xorshift >> 17);
   xorshift = xorshift ^ (xorshift << 5);
endfunction
always #10 clk = ~clk;
tmsd_board brd(.strapOn(strapOn), .code(code), .modeSelectHigh(hi),
   .modeSelectLow(lo), .testResetPin(trst));
tmsd_test_mode_select_decode DUT(.clk(clk), .resetn(resetn),
   .modeSelectHigh(hi), .modeSelectLow(lo), .testResetPin(trst),
   .nmiPin(nmiPin), .boundaryScanMode(bs), .emulationMode(emu),
   .reservedMode(rsv), .runEnable(run), .scanTrstConflict(conf),
   .nmiPulse(np));
task chk(input [31:0] nm, input e, input g); begin
   checks_done = checks_done + 1;
   if (g !== e) begin
      n_errors = n_errors + 1;
      $display("wrong value %0s expected %b seen %b", nm, e, g);
   end
end endtask
task modes(input integer m); begin
   chk("scan", m == 0, bs);
   chk("rsv", m == 1 || m == 2, rsv);
   chk("emu", m == 3, emu);
   chk("run", 1'b1, run);
   chk("trst", 1'b0, conf);
end endtask
task complete_run; begin
   $display("checks %0d mismatches %0d", checks_done, n_errors);
   if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
   else $display("Run complete: FAIL");
   $finish;
end endtask
initial begin
   for (i = 0; i < 5; i = i + 1) begin
      @(posedge clk) resetn <= 0;
      strapOn <= i < 4;
      code <= i[1:0];
      repeat (8) @(posedge clk);
      resetn <= 1;
      repeat (9) @(posedge clk);
      modes(i < 4 ? i : 3);
      rs = xorshift(rs);
      code <= rs[1:0];
      repeat (4) @(posedge clk);
      modes(i < 4 ? i : 3);
      $display("mode test %0d done", i);
   end
   repeat (2) begin
      @(posedge clk) nmiPin <= 1;
      repeat (10) begin @(negedge clk); p = p + np; end
      @(posedge clk) nmiPin <= 0;
      repeat (4) @(posedge clk);
   end
   chk("nmi", 1'b1, p == 2);
   $display("nmi test done");
   complete_run;
end
// Whole run needs about 3 us; allow a wide margin
initial begin #100000; n_errors = n_errors + 1; complete_run; end
endmodule
